/* rtl/rx_align_pkg.sv */
// Constants and carrier types for the receive alignment path
package rx_align_pkg;

    localparam int          CODE_W      = 10;
    localparam int          FIFO_DEPTH  = 32;
    // Comma patterns, first received symbol in bit 0
    localparam logic [6:0]  COMMA_POS   = 7'h7c;
    localparam logic [6:0]  COMMA_NEG   = 7'h03;
    // Decoded control bytes allowed in byte 0
    localparam logic [7:0]  K28_5       = 8'hbc;
    localparam logic [7:0]  K28_3       = 8'h7c;
    // Six-bit forms of K28, written abcdei
    localparam logic [5:0]  SIX_K28_NEG = 6'h0f;
    localparam logic [5:0]  SIX_K28_POS = 6'h30;
    // Balanced sub-blocks that demand a given running disparity
    localparam logic [5:0]  SIX_BAL_NEG = 6'h38;
    localparam logic [5:0]  SIX_BAL_POS = 6'h07;
    localparam logic [3:0]  FOUR_BAL_NEG = 4'hc;
    localparam logic [3:0]  FOUR_BAL_POS = 4'h3;
    // Consecutive bad characters that drop synchronization
    localparam logic [2:0]  LOSS_LIMIT  = 3'h4;
    localparam logic [1:0]  LAST_BYTE   = 2'h3;

    typedef struct packed {
        logic [7:0] b;
        logic       k;
        logic       cv;
    } char_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  k;
        logic        cv;
    } dword_t;

    typedef enum logic [1:0] {
        HUNT = 2'b01,
        SYNC = 2'b10
    } sync_t;

endpackage

/* rtl/dword_fifo.sv */
// Synchronous FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module dword_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             ov_q, ov_d, rdy_q, rdy_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             push, pop;

    // Ready is advisory: the dword in flight still lands in the spare slot
    assign push      = in_valid && (cnt_q < (AW+1)'(DEPTH));
    assign pop       = (cnt_q != '0) && (!ov_q || out_ready);
    assign in_ready  = rdy_q;
    assign out_valid = ov_q;
    assign out_data  = od_q;

    always_comb begin
        wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
        ov_d  = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        od_d  = pop ? mem[rp_q] : od_q;
        // One slot of slack for the dword already in flight
        rdy_d = cnt_d < (AW+1)'(DEPTH - 1);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
            rdy_q <= 1'b0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
            rdy_q <= rdy_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    no_overflow_a: assert property (@(posedge clk) disable iff (!resetn)
        in_valid |-> cnt_q < (AW+1)'(DEPTH))
        else $error("FIFO written while full");

endmodule // dword_fifo
`default_nettype wire

/* rtl/rx_dword_align.sv */
// Comma alignment, 8b/10b decode and dword assembly of the receive path
`timescale 1ns/1ps
`default_nettype none
module rx_dword_align (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic [rx_align_pkg::CODE_W-1:0] rx_code,
    input  wire logic                         rx_valid,
    output logic                              rx_ready,
    output rx_align_pkg::dword_t              dw_out,
    output logic                              dw_valid,
    input  wire logic                         dw_ready,
    output logic                              synced
);
    import rx_align_pkg::*;

    // Five-bit data value from abcdei, bit 5 ok
    function automatic logic [5:0] dec6(input logic [5:0] s);
        unique case (s)
            6'h27, 6'h18: dec6 = 6'h20;
            6'h1d, 6'h22: dec6 = 6'h21;
            6'h2d, 6'h12: dec6 = 6'h22;
            6'h31:        dec6 = 6'h23;
            6'h35, 6'h0a: dec6 = 6'h24;
            6'h29:        dec6 = 6'h25;
            6'h19:        dec6 = 6'h26;
            6'h38, 6'h07: dec6 = 6'h27;
            6'h39, 6'h06: dec6 = 6'h28;
            6'h25:        dec6 = 6'h29;
            6'h15:        dec6 = 6'h2a;
            6'h34:        dec6 = 6'h2b;
            6'h0d:        dec6 = 6'h2c;
            6'h2c:        dec6 = 6'h2d;
            6'h1c:        dec6 = 6'h2e;
            6'h17, 6'h28: dec6 = 6'h2f;
            6'h1b, 6'h24: dec6 = 6'h30;
            6'h23:        dec6 = 6'h31;
            6'h13:        dec6 = 6'h32;
            6'h32:        dec6 = 6'h33;
            6'h0b:        dec6 = 6'h34;
            6'h2a:        dec6 = 6'h35;
            6'h1a:        dec6 = 6'h36;
            6'h3a, 6'h05: dec6 = 6'h37;
            6'h33, 6'h0c: dec6 = 6'h38;
            6'h26:        dec6 = 6'h39;
            6'h16:        dec6 = 6'h3a;
            6'h36, 6'h09: dec6 = 6'h3b;
            6'h0e:        dec6 = 6'h3c;
            6'h2e, 6'h11: dec6 = 6'h3d;
            6'h1e, 6'h21: dec6 = 6'h3e;
            6'h2b, 6'h14: dec6 = 6'h3f;
            default:      dec6 = 6'h00;
        endcase
    endfunction

    // Three-bit value from fghj, bit 3 ok
    function automatic logic [3:0] dec4(input logic [3:0] s);
        unique case (s)
            4'hb, 4'h4:             dec4 = 4'h8;
            4'h9:                   dec4 = 4'h9;
            4'h5:                   dec4 = 4'ha;
            4'hc, 4'h3:             dec4 = 4'hb;
            4'hd, 4'h2:             dec4 = 4'hc;
            4'ha:                   dec4 = 4'hd;
            4'h6:                   dec4 = 4'he;
            4'he, 4'h1, 4'h7, 4'h8: dec4 = 4'hf;
            default:                dec4 = 4'h0;
        endcase
    endfunction

    sync_t       state_q, state_d;
    logic [9:0]  prev_q, prev_d, cur_q, cur_d;
    logic        v1_q, v1_d;
    logic [3:0]  off_q, off_d;
    logic        rd_q, rd_d;
    char_t       ch_q, ch_d;
    logic        chv_q, chv_d, comma_q, comma_d;
    logic [1:0]  idx_q, idx_d;
    logic [2:0]  bad_q, bad_d;
    dword_t      acc_q, acc_d;
    logic        push_q, push_d;
    logic        take;

    logic [19:0] win;
    logic        hit;
    logic [3:0]  hit_off, use_off;
    logic [9:0]  code;
    logic [5:0]  six, d6;
    logic [3:0]  four, d4;
    logic        is_k28, ok, rd_mid, disp_ok;
    logic [2:0]  ones6;
    logic [2:0]  ones4;
    logic [1:0]  pos;
    logic        pos_cv;

    assign take = rx_valid && rx_ready;

    // Capture stage: keep the last two ten-bit words
    always_comb begin
        prev_d = prev_q;
        cur_d  = cur_q;
        v1_d   = take;
        if (take) begin
            prev_d = cur_q;
            cur_d  = rx_code;
        end
    end

    // Comma search over every start position in the older word
    always_comb begin
        win     = {cur_q, prev_q};
        hit     = 1'b0;
        hit_off = '0;
        for (int i = 0; i < CODE_W; i++) begin
            if (!hit && (win[i +: 7] == COMMA_POS ||
                         win[i +: 7] == COMMA_NEG)) begin
                hit     = 1'b1;
                hit_off = 4'(i);
            end
        end
        // Boundary changes only when a comma is seen
        use_off = hit ? hit_off : off_q;
        code    = win[use_off +: 10];
    end

    // Character decode with disparity check
    always_comb begin
        six    = {code[0], code[1], code[2], code[3], code[4], code[5]};
        four   = {code[6], code[7], code[8], code[9]};
        is_k28 = (six == SIX_K28_NEG) || (six == SIX_K28_POS);
        d6     = dec6(six);
        // Rd-plus K28 uses the inverted balanced fghj forms
        d4     = dec4((six == SIX_K28_POS) ? ~four : four);
        ones6  = 3'($countones(six));
        ones4  = 3'($countones(four));
        disp_ok = 1'b1;
        if ((ones6 > 3'd3 && rd_q) || (ones6 < 3'd3 && !rd_q) ||
            (six == SIX_BAL_NEG && rd_q) || (six == SIX_BAL_POS && !rd_q)) begin
            disp_ok = 1'b0;
        end
        rd_mid = (ones6 == 3'd3) ? rd_q : (ones6 > 3'd3);
        if ((ones4 > 3'd2 && rd_mid) || (ones4 < 3'd2 && !rd_mid) ||
            (four == FOUR_BAL_NEG && rd_mid) ||
            (four == FOUR_BAL_POS && !rd_mid)) begin
            disp_ok = 1'b0;
        end
        rd_d = rd_q;
        if (v1_q) begin
            rd_d = (ones4 == 3'd2) ? rd_mid : (ones4 > 3'd2);
        end
        ok       = (is_k28 || d6[5]) && d4[3];
        chv_d    = v1_q;
        comma_d  = v1_q && hit;
        ch_d.b   = {d4[2:0], is_k28 ? 5'h1c : d6[4:0]};
        ch_d.k   = is_k28;
        ch_d.cv  = !ok || !disp_ok;
    end

    // Synchronization state and boundary offset
    always_comb begin
        state_d = state_q;
        off_d   = off_q;
        bad_d   = bad_q;
        if (chv_q && state_q == SYNC) begin
            bad_d = pos_cv ? 3'(bad_q + 1'b1) : '0;
            if (pos_cv && bad_d == LOSS_LIMIT) begin
                state_d = HUNT;
                bad_d   = '0;
            end
        end
        // A fresh comma outranks a loss of sync in the same cycle
        if (v1_q && hit) begin
            state_d = SYNC;
            off_d   = hit_off;
        end
    end

    // Byte position and position-dependent violations
    always_comb begin
        pos    = comma_q ? 2'h0 : idx_q;
        pos_cv = ch_q.cv;
        if (pos == 2'h0) begin
            if (ch_q.k && ch_q.b != K28_5 && ch_q.b != K28_3) begin
                pos_cv = 1'b1;
            end
        end else if (ch_q.k) begin
            pos_cv = 1'b1;
        end
    end

    // Dword assembly, byte 0 in the low lane
    always_comb begin
        idx_d  = idx_q;
        acc_d  = acc_q;
        push_d = 1'b0;
        if (chv_q && state_q == SYNC) begin
            if (pos == 2'h0) begin
                acc_d.cv = 1'b0;
            end
            acc_d.data[pos*8 +: 8] = ch_q.b;
            acc_d.k[pos]           = ch_q.k;
            acc_d.cv               = acc_d.cv | pos_cv;
            idx_d  = 2'(pos + 1'b1);
            push_d = (pos == LAST_BYTE);
        end else if (state_q == HUNT) begin
            idx_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= HUNT;
            prev_q  <= '0;
            cur_q   <= '0;
            v1_q    <= 1'b0;
            off_q   <= '0;
            rd_q    <= 1'b0;
            ch_q    <= '0;
            chv_q   <= 1'b0;
            comma_q <= 1'b0;
            idx_q   <= '0;
            bad_q   <= '0;
            acc_q   <= '0;
            push_q  <= 1'b0;
            synced  <= 1'b0;
        end else begin
            state_q <= state_d;
            prev_q  <= prev_d;
            cur_q   <= cur_d;
            v1_q    <= v1_d;
            off_q   <= off_d;
            rd_q    <= rd_d;
            ch_q    <= ch_d;
            chv_q   <= chv_d;
            comma_q <= comma_d;
            idx_q   <= idx_d;
            bad_q   <= bad_d;
            acc_q   <= acc_d;
            push_q  <= push_d;
            synced  <= (state_d == SYNC);
        end
    end

    dword_fifo #(
        .WIDTH ($bits(dword_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_data   (acc_q),
        .in_valid  (push_q),
        .in_ready  (rx_ready),
        .out_data  (dw_out),
        .out_valid (dw_valid),
        .out_ready (dw_ready)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    comma_lock_a: assert property (v1_q && hit |=> state_q == SYNC)
        else $error("Comma did not establish sync");

    slip_at_comma_a: assert property ($changed(off_q) |-> $past(v1_q && hit))
        else $error("Boundary moved without a comma");

    bad_code_a: assert property (v1_q && !(is_k28 || d6[5]) |=> ch_q.cv)
        else $error("Undecodable character not flagged");

    byte0_ctrl_a: assert property (chv_q && state_q == SYNC && pos == 2'h0
        && ch_q.k && ch_q.b != K28_5 && ch_q.b != K28_3 |=> acc_q.cv)
        else $error("Illegal control in byte 0 not flagged");

    upper_ctrl_a: assert property (chv_q && state_q == SYNC && pos != 2'h0
        && ch_q.k |=> acc_q.cv)
        else $error("Control in bytes 1-3 not flagged");

    comma_detect_a: assert property (v1_q && win[6:0] == COMMA_POS
        |=> comma_q && off_q == 4'h0)
        else $error("Comma at offset 0 missed");

    dword_emit_a: assert property (chv_q && state_q == SYNC && comma_q
        ##1 chv_q [*3] |=> push_q && acc_q.data[7:0] == K28_5)
        else $error("Aligned dword not emitted from comma");

    kflag_a: assert property (v1_q |=> ch_q.k ==
        ($past(code[5:0]) == 6'h3c || $past(code[5:0]) == 6'h03))
        else $error("Control flag mismatch");

    dword_cv_a: assert property (chv_q && state_q == SYNC && pos_cv
        && pos == LAST_BYTE |=> push_q && acc_q.cv)
        else $error("Dword lost its violation flag");

endmodule // rx_dword_align
`default_nettype wire

/* verification/link_tx_model.sv */
// Link transmitter model feeding raw ten-bit words
`timescale 1ns/1ps
`default_nettype none
module link_tx_model (
    input  wire logic                            clk,
    output logic [rx_align_pkg::CODE_W-1:0]      rx_code,
    output logic                                 rx_valid,
    input  wire logic                            rx_ready
);
    import rx_align_pkg::*;
    bit          bits_q[$];
    logic        rd_q = 1'b0;
    logic [9:0]  w;
    int          i;

    initial begin
        rx_code  = '0;
        rx_valid = 1'b0;
    end

    // Form at negative disparity, symbol a in bit 0
    function automatic logic [9:0] code_of(input logic [7:0] b,
                                           input logic k);
        case ({k, b})
            9'h1bc:  return 10'h17c;
            9'h17c:  return 10'h33c;
            9'h11c:  return 10'h0bc;
            9'h0b5:  return 10'h155;
            9'h04a:  return 10'h2aa;
            9'h055:  return 10'h295;
            default: return 10'h16a;
        endcase
    endfunction

    task automatic clear();
        bits_q.delete();
        rd_q = 1'b0;
    endtask

    // Alternating filler shifts the character phase
    task automatic skew(input int n);
        for (int j = 0; j < n; j++)
            bits_q.push_back(bit'((n - 1 - j) % 2));
    endtask

    // Bad selects the wrong disparity form of a control
    task automatic put(input logic [7:0] b, input logic k, input logic bad);
        logic [9:0] c;
        c = code_of(b, k);
        if (k && (rd_q ^ bad))
            c = ~c;
        // Only unbalanced characters flip the running disparity
        if ($countones(c) != 5)
            rd_q = ~rd_q;
        for (int j = 0; j < 10; j++)
            bits_q.push_back(c[j]);
    endtask

    always @(posedge clk) begin
        if (rx_valid && rx_ready && bits_q.size() >= 10)
            repeat (10) void'(bits_q.pop_front());
        if (bits_q.size() >= 10) begin
            for (i = 0; i < 10; i++)
                w[i] = bits_q[i];
            rx_code  <= w;
            rx_valid <= 1'b1;
        end else begin
            // Idle link inverts the held word on every idle clock
            rx_code  <= ~rx_code;
            rx_valid <= 1'b0;
        end
    end
endmodule // link_tx_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the receive alignment path
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rx_align_pkg::*;
    localparam logic [31:0] ALIGN_DW = 32'h554ab5bc;
    logic              clk       = 1'b0;
    logic              resetn    = 1'b0;
    logic [CODE_W-1:0] rx_code;
    logic              rx_valid;
    logic              rx_ready;
    dword_t            dw_out;
    logic              dw_valid;
    logic              dw_ready  = 1'b1;
    logic              synced;
    dword_t            exp_q[$];
    int                err_total = 0;
    int                tests_run = 0;
    logic [7:0]        pat [4]   = '{8'hb5, 8'h4a, 8'h55, 8'haa};

    always #4 clk = ~clk;

    rx_dword_align i_rx_dword_align (.clk(clk), .resetn(resetn),
        .rx_code(rx_code), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .dw_out(dw_out), .dw_valid(dw_valid), .dw_ready(dw_ready),
        .synced(synced));

    link_tx_model i_link_tx_model (.clk(clk), .rx_code(rx_code),
        .rx_valid(rx_valid), .rx_ready(rx_ready));

    task automatic fail(input string msg);
        $display("unexpected at %0t: %s", $time, msg);
        err_total++;
    endtask

    task automatic cmp_dw(input dword_t got, input dword_t exp);
        tests_run++;
        if (got !== exp)
            fail($sformatf("dword %h, want %h", got, exp));
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string m);
        tests_run++;
        if (got !== exp)
            fail(m);
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Reset, then idle characters ahead of any comma
    task automatic restart(input int n);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        i_link_tx_model.clear();
        exp_q.delete();
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        i_link_tx_model.skew(n);
        repeat (2) i_link_tx_model.put(8'h4a, 1'b0, 1'b0);
        // Let the buffer raise ready before scenarios look at it
        repeat (2) @(posedge clk);
    endtask

    task automatic put_dw(input logic [31:0] d, input logic [3:0] k,
                          input logic [3:0] bad, input logic cv);
        for (int j = 0; j < 4; j++)
            i_link_tx_model.put(d[8*j +: 8], k[j], bad[j]);
        exp_q.push_back('{d, k, cv});
    endtask

    task automatic drain();
        repeat (3) i_link_tx_model.put(8'h4a, 1'b0, 1'b0);
        for (int n = 0; n < 2000 && exp_q.size() > 0; n++)
            @(posedge clk);
        cmp_bit(exp_q.size() == 0, 1'b1, "dwords missing");
    endtask

    always @(posedge clk) begin
        if (resetn && dw_valid && dw_ready) begin
            if (exp_q.size() == 0)
                fail("surplus dword");
            else
                cmp_dw(dw_out, exp_q.pop_front());
        end
    end

    task automatic sc_align(input int n);
        restart(n);
        repeat (30) @(posedge clk);
        cmp_bit(synced, 1'b0, "sync without comma");
        put_dw(ALIGN_DW, 4'h1, 4'h0, 1'b0);
        put_dw(32'haa55b54a, 4'h0, 4'h0, 1'b0);
        put_dw(32'h4a55aab5, 4'h0, 4'h0, 1'b0);
        drain();
        cmp_bit(synced, 1'b1, "no sync after comma");
    endtask

    task automatic sc_codes();
        restart(5);
        put_dw(ALIGN_DW, 4'h1, 4'h0, 1'b0);
        put_dw(32'h55aa4a1c, 4'h1, 4'h0, 1'b1);
        put_dw(32'h554ab57c, 4'h1, 4'h0, 1'b0);
        put_dw(32'h557c4ab5, 4'h4, 4'h0, 1'b1);
        put_dw(32'h554ab57c, 4'h1, 4'h1, 1'b1);
        // Four violating characters in a row drop synchronization
        put_dw(32'h1c1c1c1c, 4'hf, 4'h0, 1'b1);
        drain();
        cmp_bit(synced, 1'b0, "sync kept through violations");
    endtask

    // Consumer stalls until the buffer refuses input
    task automatic sc_full();
        restart(9);
        dw_ready <= 1'b0;
        put_dw(ALIGN_DW, 4'h1, 4'h0, 1'b0);
        for (int j = 0; j < 39; j++)
            put_dw({pat[(j+3)%4], pat[(j+2)%4], pat[(j+1)%4], pat[j%4]},
                   4'h0, 4'h0, 1'b0);
        for (int n = 0; n < 1000 && rx_ready !== 1'b0; n++)
            @(posedge clk);
        cmp_bit(rx_ready, 1'b0, "input not refused");
        cmp_bit(dw_valid, 1'b1, "output not held");
        dw_ready <= 1'b1;
        drain();
    endtask

    initial begin
        #200000;
        fail("watchdog expired");
        end_sim();
    end

    initial begin
        sc_align(0);
        sc_align(3);
        sc_align(9);
        sc_codes();
        sc_full();
        end_sim();
    end
endmodule // tb
`default_nettype wire
